// ===== common/emt_pkg.sv
/*
  emt_pkg: widths, reset values, timing counts and state types of the
  emulator takeover and i/o space block.
  assumes a single 250 MHz processor clock.
*/
package emt_pkg;
  // clock and i/o strobe timing
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned IO_STROBE_NS = 12;
  localparam int unsigned IO_STROBE_CYC = (IO_STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // widths
  localparam int unsigned IO_ADDR_W = 11;
  localparam int unsigned DREG_W = 16;
  localparam int unsigned DREG_N = 16;
  localparam int unsigned DREG_IDX_W = 4;
  localparam int unsigned MODE_W = 3;
  localparam int unsigned IO_CNT_W = 2;
  // counts and reset values
  localparam logic [IO_CNT_W-1:0] IO_CNT_LAST = IO_CNT_W'(IO_STROBE_CYC - 1);
  localparam logic [IO_CNT_W-1:0] IO_CNT_RST = 2'h0;
  localparam logic [MODE_W-1:0] BOOT_MODE_RST = 3'h0;
  localparam logic [IO_ADDR_W-1:0] IO_ADDR_RST = 11'h000;
  localparam logic [DREG_W-1:0] DREG_RST = 16'h0000;

  // i/o access sequencer states
  typedef enum logic [1:0]
  {
    IO_IDLE = 2'b00,
    IO_STROBE = 2'b01,
    IO_DONE = 2'b10
  } emt_io_st_t;

  // whole state of the block
  typedef struct packed {
    logic ee_m;
    logic ee_q;
    logic rst_m;
    logic rst_q;
    logic erst_m;
    logic erst_q;
    logic br_m;
    logic br_q;
    logic ebr_m;
    logic ebr_q;
    logic [MODE_W-1:0] mode_m;
    logic [MODE_W-1:0] mode_q;
    logic [DREG_W-1:0] iod_m;
    logic [DREG_W-1:0] iod_q;
    logic core_rst_n;
    logic [MODE_W-1:0] boot_mode;
    logic grant_n;
    logic bg_oe;
    logic release_bus;
    emt_io_st_t io_st;
    logic [IO_CNT_W-1:0] io_cnt;
    logic io_is_wr;
    logic [DREG_IDX_W-1:0] io_idx;
    logic [IO_ADDR_W-1:0] io_addr;
    logic [DREG_W-1:0] io_wdata;
    logic io_doe;
    logic io_rd_n;
    logic io_wr_n;
    logic io_done;
    logic [DREG_W-1:0] io_rdata;
    logic [DREG_N-1:0][DREG_W-1:0] dregs;
  } emt_state_t;
endpackage : emt_pkg

// ===== design/emt_takeover.sv
/*
  emt_takeover: emulator takeover of reset and bus arbitration, boot mode
  latch, and the i/o space access sequencer with its sixteen data registers.
  assumes pins arrive asynchronously; core status inputs are on i_clk.
*/
// Function
// - i/o read and write move a value between one of sixteen data registers and i/o address 0..2047.
// - the three boot mode pins are captured when chip reset deasserts.
// - an emulator reset is a full chip reset that recaptures the mode pins on release.
// - with emulator enable set, reset, bus request and bus grant use the emulator pins.
// - with emulator enable set, the normal bus grant output is three-stated.
// - during emulation target reset and bus request are ignored while stepping or halted.
// - a target master may drive the bus only while the processor asserts bus grant.
// - emulator pins have no effect unless emulation is in progress.
// - an idle processor grants a bus request next cycle, releasing its bus and halting.
// - bus request handling works at all times, also while reset is held.
`timescale 1ns/10ps
module emt_takeover
  import emt_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_emu_enable,
  input wire logic i_reset_n,
  input wire logic i_emu_reset_n,
  input wire logic i_bus_request_n,
  input wire logic i_emu_bus_request_n,
  input wire logic [MODE_W-1:0] i_mode,
  input wire logic i_single_step,
  input wire logic i_emu_halted,
  input wire logic i_ext_access,
  input wire logic i_io_req,
  input wire logic i_io_wr,
  input wire logic [DREG_IDX_W-1:0] i_io_dreg,
  input wire logic [IO_ADDR_W-1:0] i_io_addr,
  input wire logic [DREG_W-1:0] i_io_data,
  input wire logic i_dreg_load,
  input wire logic [DREG_IDX_W-1:0] i_dreg_idx,
  input wire logic [DREG_W-1:0] i_dreg_wdata,
  output logic o_core_reset_n,
  output logic [MODE_W-1:0] o_boot_mode,
  output logic o_bus_grant_n,
  output logic o_bus_grant_n_oe,
  output logic o_emu_bus_grant_n,
  output logic o_bus_release,
  output logic [IO_ADDR_W-1:0] o_io_addr,
  output logic [DREG_W-1:0] o_io_data,
  output logic o_io_data_oe,
  output logic o_io_rd_n,
  output logic o_io_wr_n,
  output logic o_io_done,
  output logic [DREG_W-1:0] o_io_rdata
);

  emt_state_t s_q;
  emt_state_t s_d;
  logic gate_target;
  logic rst_sel;
  logic br_eff;
  logic io_start;

  // pick the active reset and request pins
  always_comb
  begin
    gate_target = s_q.ee_q & (i_single_step | i_emu_halted);
    if (s_q.ee_q)
    begin
      rst_sel = s_q.erst_q & (s_q.rst_q | gate_target);
      br_eff = ~s_q.ebr_q | (~s_q.br_q & ~gate_target);
    end
    else
    begin
      rst_sel = s_q.rst_q;
      br_eff = ~s_q.br_q;
    end
    // bus request has priority over starting an i/o access
    io_start = (s_q.io_st == IO_IDLE) & i_io_req & s_q.grant_n & ~br_eff;
  end

  // next state
  always_comb
  begin
    s_d = s_q;
    // two-stage synchronisers for all pins
    s_d.ee_m = i_emu_enable;
    s_d.ee_q = s_q.ee_m;
    s_d.rst_m = i_reset_n;
    s_d.rst_q = s_q.rst_m;
    s_d.erst_m = i_emu_reset_n;
    s_d.erst_q = s_q.erst_m;
    s_d.br_m = i_bus_request_n;
    s_d.br_q = s_q.br_m;
    s_d.ebr_m = i_emu_bus_request_n;
    s_d.ebr_q = s_q.ebr_m;
    s_d.mode_m = i_mode;
    s_d.mode_q = s_q.mode_m;
    s_d.iod_m = i_io_data;
    s_d.iod_q = s_q.iod_m;
    // reset follows the selected pin; mode latched on release
    s_d.core_rst_n = rst_sel;
    if (rst_sel && !s_q.core_rst_n)
    begin
      s_d.boot_mode = s_q.mode_q;
    end
    // bus arbitration, independent of core reset
    s_d.bg_oe = ~s_q.ee_q;
    if (!br_eff)
    begin
      s_d.grant_n = 1'b1;
    end
    else if (!i_ext_access && s_q.io_st == IO_IDLE)
    begin
      s_d.grant_n = 1'b0;
    end
    s_d.release_bus = ~s_d.grant_n;
    // data register load from the core
    if (i_dreg_load)
    begin
      s_d.dregs[i_dreg_idx] = i_dreg_wdata;
    end
    // i/o access sequencer
    s_d.io_done = 1'b0;
    case (s_q.io_st)
      IO_IDLE:
      begin
        if (io_start)
        begin
          s_d.io_st = IO_STROBE;
          s_d.io_cnt = IO_CNT_RST;
          s_d.io_is_wr = i_io_wr;
          s_d.io_idx = i_io_dreg;
          s_d.io_addr = i_io_addr;
          s_d.io_wdata = s_q.dregs[i_io_dreg];
          s_d.io_doe = i_io_wr;
          s_d.io_rd_n = i_io_wr;
          s_d.io_wr_n = ~i_io_wr;
        end
      end
      IO_STROBE:
      begin
        s_d.io_cnt = s_q.io_cnt + 2'h1;
        if (s_q.io_cnt == IO_CNT_LAST)
        begin
          s_d.io_st = IO_DONE;
          s_d.io_rd_n = 1'b1;
          s_d.io_wr_n = 1'b1;
          s_d.io_doe = 1'b0;
          s_d.io_done = 1'b1;
          if (!s_q.io_is_wr)
          begin
            s_d.io_rdata = s_q.iod_q;
            s_d.dregs[s_q.io_idx] = s_q.iod_q;
          end
        end
      end
      IO_DONE:
      begin
        s_d.io_st = IO_IDLE;
      end
      default:
      begin
        s_d.io_st = IO_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      s_q <= '{ee_m: 1'b0, ee_q: 1'b0, rst_m: 1'b0, rst_q: 1'b0, erst_m: 1'b1,
               erst_q: 1'b1, br_m: 1'b1, br_q: 1'b1, ebr_m: 1'b1, ebr_q: 1'b1,
               mode_m: BOOT_MODE_RST, mode_q: BOOT_MODE_RST, iod_m: DREG_RST,
               iod_q: DREG_RST, core_rst_n: 1'b0, boot_mode: BOOT_MODE_RST,
               grant_n: 1'b1, bg_oe: 1'b1, release_bus: 1'b0, io_st: IO_IDLE,
               io_cnt: IO_CNT_RST, io_is_wr: 1'b0, io_idx: 4'h0,
               io_addr: IO_ADDR_RST, io_wdata: DREG_RST, io_doe: 1'b0,
               io_rd_n: 1'b1, io_wr_n: 1'b1, io_done: 1'b0, io_rdata: DREG_RST,
               dregs: '0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign o_core_reset_n = s_q.core_rst_n;
  assign o_boot_mode = s_q.boot_mode;
  assign o_bus_grant_n = s_q.grant_n;
  assign o_bus_grant_n_oe = s_q.bg_oe;
  assign o_emu_bus_grant_n = s_q.grant_n;
  assign o_bus_release = s_q.release_bus;
  assign o_io_addr = s_q.io_addr;
  assign o_io_data = s_q.io_wdata;
  assign o_io_data_oe = s_q.io_doe;
  assign o_io_rd_n = s_q.io_rd_n;
  assign o_io_wr_n = s_q.io_wr_n;
  assign o_io_done = s_q.io_done;
  assign o_io_rdata = s_q.io_rdata;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  a_io_addr_data: assert property (io_start |=> o_io_addr == $past(i_io_addr)
                                   && o_io_data == $past(s_q.dregs[i_io_dreg]))
    else $error("io address or data not taken at start");
  a_mode_capture: assert property ($rose(o_core_reset_n) |-> o_boot_mode == $past(s_q.mode_q))
    else $error("boot mode not captured at reset release");
  a_emu_reset: assert property (s_q.ee_q && !s_q.erst_q |=> !o_core_reset_n)
    else $error("emulator reset did not reset the chip");
  a_emu_br_sel: assert property (s_q.ee_q && !s_q.ebr_q && !i_ext_access
                                 && s_q.io_st == IO_IDLE |=> !o_emu_bus_grant_n)
    else $error("emulator bus request not granted");
  a_bg_hiz: assert property (s_q.ee_q |=> !o_bus_grant_n_oe)
    else $error("bus grant driven during emulation");
  a_step_ignore: assert property (s_q.ee_q && s_q.erst_q && s_q.ebr_q && gate_target
                                  |=> o_core_reset_n && o_bus_grant_n)
    else $error("target pins acted while stepping or halted");
  a_grant_io: assert property (!o_bus_grant_n |-> o_io_rd_n && o_io_wr_n && !o_io_data_oe)
    else $error("processor drives bus while granted");
  a_emu_idle: assert property (!s_q.ee_q && s_q.rst_q && s_q.br_q
                               |=> o_core_reset_n && o_bus_grant_n)
    else $error("emulator pins acted outside emulation");
  a_grant_next: assert property (br_eff && !i_ext_access && s_q.io_st == IO_IDLE
                                 |=> !o_bus_grant_n && o_bus_release)
    else $error("bus request not granted next cycle");
  a_ee_sync: assert property (!i_emu_enable && !s_q.ee_m ##1 i_emu_enable |=> !s_q.ee_q)
    else $error("emulator enable not synchronised");
  a_io_strobe: assert property (io_start |=> (!o_io_rd_n || !o_io_wr_n) [*3] ##1 o_io_done)
    else $error("io strobe length wrong");

  c_grant: cover property (br_eff ##1 !o_bus_grant_n ##[1:20] o_bus_grant_n);
  c_io_read: cover property (io_start && !i_io_wr ##[1:8] o_io_done);
  c_emu_reset: cover property (s_q.ee_q && !s_q.erst_q ##[1:20] $rose(o_core_reset_n));
endmodule : emt_takeover

// ===== verif/emt_partner.sv
/*
  emt_partner: target bus master and i/o peripheral beside emt_takeover.
  assumes the bench changes its commands just after rising edges of i_clk.
*/
`timescale 1ns/10ps
module emt_partner
  import emt_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_want_bus,
  input wire logic i_grant_n,
  input wire logic i_rd_n,
  input wire logic [DREG_W-1:0] i_rd_value,
  output logic o_bus_request_n,
  output logic o_driving,
  output logic [DREG_W-1:0] o_io_data
);
  logic [DREG_W-1:0] last_q = '0;
  // request follows the bench command; bus taken only under grant
  assign o_bus_request_n = !i_want_bus;
  assign o_driving = i_want_bus && !i_grant_n;
  // peripheral answers while selected, else a value toggling every cycle
  assign o_io_data = !i_rd_n ? i_rd_value : ~last_q;
  always_ff @(posedge i_clk)
  begin
    last_q <= o_io_data;
  end
endmodule : emt_partner

// ===== verif/emt_takeover_tb.sv
/*
  emt_takeover_tb: self-checking bench for emt_takeover with a behavioural
  data register model. assumes emt_pkg and emt_partner compiled first.
*/
`timescale 1ns/10ps
module emt_takeover_tb
  import emt_pkg::*;
;
  logic i_clk = 1'b0, i_resetn = 1'b0, ee = 1'b0, rst_n = 1'b0, erst_n = 1'b1;
  logic ebr_n = 1'b1, step = 1'b0, halted = 1'b0, ext = 1'b0, want = 1'b0;
  logic io_req = 1'b0, io_wr = 1'b0, dreg_load = 1'b0;
  logic [MODE_W-1:0] mode = '0, m;
  logic [DREG_IDX_W-1:0] io_dreg = '0, dreg_idx = '0;
  logic [IO_ADDR_W-1:0] io_addr = '0, ioa;
  logic [DREG_W-1:0] dreg_wdata = '0, rd_value = '0, pdata, iod, rdata;
  logic br_n, driving, core_rst_n, bg_n, bg_oe, ebg_n, rel, iod_oe, rd_n, wr_n, done;
  logic [MODE_W-1:0] boot;
  int fail_count = 0, n_checks = 0, i, idx, adr, model[DREG_N];

  emt_takeover emt_takeover_inst (.i_clk(i_clk), .i_resetn(i_resetn), .i_emu_enable(ee),
    .i_reset_n(rst_n), .i_emu_reset_n(erst_n), .i_bus_request_n(br_n),
    .i_emu_bus_request_n(ebr_n), .i_mode(mode), .i_single_step(step),
    .i_emu_halted(halted), .i_ext_access(ext), .i_io_req(io_req), .i_io_wr(io_wr),
    .i_io_dreg(io_dreg), .i_io_addr(io_addr), .i_io_data(pdata), .i_dreg_load(dreg_load),
    .i_dreg_idx(dreg_idx), .i_dreg_wdata(dreg_wdata), .o_core_reset_n(core_rst_n),
    .o_boot_mode(boot), .o_bus_grant_n(bg_n), .o_bus_grant_n_oe(bg_oe),
    .o_emu_bus_grant_n(ebg_n), .o_bus_release(rel), .o_io_addr(ioa), .o_io_data(iod),
    .o_io_data_oe(iod_oe), .o_io_rd_n(rd_n), .o_io_wr_n(wr_n), .o_io_done(done),
    .o_io_rdata(rdata));
  emt_partner emt_partner_inst (.i_clk(i_clk), .i_want_bus(want), .i_grant_n(ebg_n),
    .i_rd_n(rd_n), .i_rd_value(rd_value), .o_bus_request_n(br_n), .o_driving(driving),
    .o_io_data(pdata));

  // clock and watchdog
  initial
  begin
    forever #2 i_clk = ~i_clk;
  end
  initial
  begin
    repeat (5000) @(posedge i_clk);
    fail_count++;
    conclude();
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [DREG_W-1:0] got, exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : settle

  task automatic load(input int ix, input int v);
    @(posedge i_clk);
    dreg_load <= 1'b1;
    dreg_idx <= DREG_IDX_W'(ix);
    dreg_wdata <= DREG_W'(v);
    model[ix] = v;
    @(posedge i_clk);
    dreg_load <= 1'b0;
  endtask : load

  // one i/o transfer; address and write data checked each strobe cycle, strobe length and read data at the end
  task automatic io(input logic wr, input int ix, input int ad, input int exp);
    int k, ns;
    ns = 0;
    @(posedge i_clk);
    io_req <= 1'b1;
    io_wr <= wr;
    io_dreg <= DREG_IDX_W'(ix);
    io_addr <= IO_ADDR_W'(ad);
    rd_value <= DREG_W'(exp);
    for (k = 0; k < 8 && done !== 1'b1; k++)
    begin
      settle(1);
      if ((wr ? wr_n : rd_n) === 1'b0)
      begin
        ns++;
        chk("io addr", DREG_W'(ioa), DREG_W'(ad));
        chk("io oe", iod_oe, wr);
        if (wr)
          chk("io data", iod, DREG_W'(exp));
      end
    end
    chk("done", done, 1'b1);
    chk("strobes", DREG_W'(ns), DREG_W'(IO_STROBE_CYC));
    if (!wr)
      chk("rdata", rdata, DREG_W'(exp));
    @(posedge i_clk);
    io_req <= 1'b0;
  endtask : io

  // main sequence
  initial
  begin
    void'($urandom(32'hba8ea0c6));
    repeat (20) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    want <= 1'b1;
    settle(3);
    chk("core rst", core_rst_n, 1'b0);
    chk("grant", bg_n, 1'b0);
    chk("release", rel, 1'b1);
    chk("target", driving, 1'b1);
    @(posedge i_clk);
    want <= 1'b0;
    settle(3);
    chk("grant off", ebg_n, 1'b1);
    // request during an external access waits for its end
    @(posedge i_clk);
    ext <= 1'b1;
    want <= 1'b1;
    settle(3);
    chk("ext hold", bg_n, 1'b1);
    @(posedge i_clk);
    ext <= 1'b0;
    settle(1);
    chk("ext grant", bg_n, 1'b0);
    @(posedge i_clk);
    want <= 1'b0;
    settle(3);
    chk("ext off", bg_n, 1'b1);
    @(posedge i_clk);
    m = MODE_W'($urandom);
    mode <= m;
    rst_n <= 1'b1;
    settle(3);
    chk("boot", DREG_W'(boot), DREG_W'(m));
    @(posedge i_clk);
    mode <= ~m;
    settle(3);
    chk("boot held", DREG_W'(boot), DREG_W'(m));
    // writes, reads into a register, then write-back of the read value
    for (i = 0; i < 4; i++)
    begin
      idx = $urandom_range(15);
      adr = i < 2 ? i * 2047 : $urandom_range(2047);
      load(idx, $urandom_range(16'hffff));
      io(1'b1, idx, adr, model[idx]);
      idx = $urandom_range(15);
      model[idx] = $urandom_range(16'hffff);
      io(1'b0, idx, 2047 - adr, model[idx]);
      io(1'b1, idx, adr, model[idx]);
    end
    // emulator pins idle without enable, then takeover
    @(posedge i_clk);
    erst_n <= 1'b0;
    ebr_n <= 1'b0;
    settle(3);
    chk("erst off", core_rst_n, 1'b1);
    chk("ebr off", bg_n, 1'b1);
    @(posedge i_clk);
    erst_n <= 1'b1;
    ebr_n <= 1'b1;
    ee <= 1'b1;
    settle(2);
    chk("oe sync", bg_oe, 1'b1);
    settle(1);
    chk("oe", bg_oe, 1'b0);
    for (i = 0; i < 2; i++)
    begin
      @(posedge i_clk);
      step <= i == 0;
      halted <= i == 1;
      want <= 1'b1;
      rst_n <= 1'b0;
      settle(3);
      chk("gated req", ebg_n, 1'b1);
      chk("gated rst", core_rst_n, 1'b1);
      chk("no drive", driving, 1'b0);
      @(posedge i_clk);
      want <= 1'b0;
      rst_n <= 1'b1;
      settle(3);
    end
    @(posedge i_clk);
    halted <= 1'b0;
    ebr_n <= 1'b0;
    settle(3);
    chk("emu grant", ebg_n, 1'b0);
    @(posedge i_clk);
    ebr_n <= 1'b1;
    m = ~m;
    mode <= m;
    erst_n <= 1'b0;
    settle(3);
    chk("emu rst", core_rst_n, 1'b0);
    @(posedge i_clk);
    erst_n <= 1'b1;
    settle(3);
    chk("emu boot", DREG_W'(boot), DREG_W'(m));
    conclude();
  end
endmodule : emt_takeover_tb
